// ==== psa_host_model.sv ====
`timescale 1ns/1ps
module psa_host_model #(
  parameter logic FAULT_ACTIVE_LEVEL = 1'b0
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        loadKey,
  input  wire logic [31:0] keyIn,
  input  wire logic [3:0]  statusRaw,
  output logic      [3:0]  faultActive,
  output logic      [31:0] globalKeyCopy_q
);
  // The IC reports the raw coupler state; the host alone decides which level means a fault.
  assign faultActive = ~(statusRaw ^ {4{FAULT_ACTIVE_LEVEL}});
  logic [31:0] keyD;
  always_comb keyD = loadKey ? keyIn : globalKeyCopy_q;
  // Volatile host memory, so a reset loses the copy.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) globalKeyCopy_q <= 32'h0000_0000;
    else globalKeyCopy_q <= keyD;
  end
endmodule

// ==== psa_pkg.sv ====
package psa_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          NUM_CHAN      = 4;
  // Register offsets (byte addresses, one aligned word each).
  localparam logic [7:0]  OFF_WP_KEY    = 8'h00;
  localparam logic [7:0]  OFF_IC_SEL    = 8'h04;
  localparam logic [7:0]  OFF_STATUS    = 8'h08;
  localparam logic [7:0]  OFF_IRQ_STAT  = 8'h0C;
  localparam logic [7:0]  OFF_IRQ_MASK  = 8'h10;
  localparam logic [7:0]  OFF_PROT_CTRL = 8'h14;
  localparam logic [7:0]  OFF_CHAN_BASE = 8'h20;
  localparam logic [7:0]  OFF_CHAN_END  = 8'h2C;
  // Field positions.
  localparam int          FMT_PD_BIT    = 3;
  localparam int          IRQ_PROT_WR   = 0;
  localparam int          IRQ_REJECT    = 1;
  localparam int          IRQ_FAULT     = 2;
  localparam int          IRQ_W         = 3;
  // Values.
  localparam logic [31:0] WP_KEY_UNLOCK = 32'hAAAA_AAAA;
  localparam logic [31:0] WP_KEY_RESET  = 32'h0000_0000;
  localparam logic [31:0] REG_ZERO      = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// ==== psa_setup_access.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Pulse-and-direction format puts step on phase-D low side, direction on high side.
// - That format is chosen only when bit 3 of the channel format control is 1.
// - Fault status bit reads 0 while the fault coupler conducts, 1 otherwise.
// - Amplifier enable has no programmable polarity; enable always drives the same relay.
// - Protected writes are accepted only while the key register holds AAAAAAAA hex.
// - After an accepted protected write the key register returns to 0.
// - Device answers as interface IC number 0 to 15 from the address switches.
// - Channel index 0 to 3 addresses hardware channels 1 to 4.
// - Indices 0 and 1 are base-board channels, 2 and 3 piggyback channels.
// - Setup elements sit in 32-bit words, some packed as partial fields.
module psa_setup_access
  import psa_pkg::*;
(
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  input  wire logic [3:0]                 address_switch_bank,
  input  wire logic [3:0]                 busIcSel,
  input  wire logic [psa_pkg::ADDR_W-1:0] busAddr,
  input  wire logic [psa_pkg::DATA_W-1:0] busWrData,
  input  wire logic                       busWr,
  input  wire logic                       busRd,
  output logic      [psa_pkg::DATA_W-1:0] busRdData,
  input  wire logic [3:0]                 stepPulse,
  input  wire logic [3:0]                 stepDir,
  input  wire logic [3:0]                 pwmLow,
  input  wire logic [3:0]                 pwmHigh,
  input  wire logic [3:0]                 ampEnable,
  input  wire logic [3:0]                 faultCouplerOn,
  output logic      [3:0]                 phase_d_low_side_output,
  output logic      [3:0]                 phase_d_high_side_output,
  output logic      [3:0]                 ampRelayOn,
  output logic      [3:0]                 channelBaseBoard,
  output logic                            irq
);
  import psa_pkg::*;

  logic                     rstMeta_q;
  logic                     rstMeta_d;
  logic                     rstSync_q;
  logic                     rstSync_d;
  logic                     rstN;
  logic [3:0]               icIdMeta_q;
  logic [3:0]               icIdMeta_d;
  logic [3:0]               icId_q;
  logic [3:0]               icId_d;
  logic [3:0]               faultMeta_q;
  logic [3:0]               faultMeta_d;
  logic [3:0]               faultSync_q;
  logic [3:0]               faultSync_d;
  logic [3:0]               faultPrev_q;
  logic [3:0]               faultPrev_d;
  logic [1:0]               faultArm_q;
  logic [1:0]               faultArm_d;
  logic                     faultArmed;
  logic [3:0]               stepMeta_q;
  logic [3:0]               stepMeta_d;
  logic [3:0]               stepSync_q;
  logic [3:0]               stepSync_d;
  logic [3:0]               dirMeta_q;
  logic [3:0]               dirMeta_d;
  logic [3:0]               dirSync_q;
  logic [3:0]               dirSync_d;

  logic [DATA_W-1:0]        write_protect_key_q;
  logic [DATA_W-1:0]        write_protect_key_d;
  logic [DATA_W-1:0]        protMask_q;
  logic [DATA_W-1:0]        protMask_d;
  logic [DATA_W-1:0]        chanFmt_q [NUM_CHAN];
  logic [DATA_W-1:0]        chanFmt_d [NUM_CHAN];
  logic [IRQ_W-1:0]         irqStat_q;
  logic [IRQ_W-1:0]         irqStat_d;
  logic [IRQ_W-1:0]         irqMask_q;
  logic [IRQ_W-1:0]         irqMask_d;
  logic [DATA_W-1:0]        rdData_q;
  logic [DATA_W-1:0]        rdData_d;

  logic                     selected;
  logic                     wrEn;
  logic                     rdEn;
  logic                     chanHit;
  logic [1:0]               chanIdx;
  logic                     isProtected;
  logic                     keyOk;
  logic                     protWrOk;
  logic                     protWrRefused;
  logic [3:0]               faultStatus;

  // Channel register index from a byte address inside the channel window.
  function automatic logic [1:0] chan_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] rel;
    rel = addr - OFF_CHAN_BASE;
    return rel[3:2];
  endfunction

  // A four-bit field read back in the low bits of an otherwise zero word.
  function automatic logic [DATA_W-1:0] nibble_word(input logic [3:0] val);
    return {28'h000_0000, val};
  endfunction

  // An interrupt register read back in the low bits of an otherwise zero word.
  function automatic logic [DATA_W-1:0] irq_word(input logic [IRQ_W-1:0] val);
    return {29'h000_0000, val};
  endfunction

  // Reset is applied asynchronously but released in step with the clock.
  always_comb begin
    rstMeta_d = 1'b1;
    rstSync_d = rstMeta_q;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= rstMeta_d;
      rstSync_q <= rstSync_d;
    end
  end
  assign rstN = rstSync_q;

  // Only the second flop of each pair feeds logic; the first may still be settling.
  always_comb begin
    icIdMeta_d  = address_switch_bank;
    icId_d      = icIdMeta_q;
    faultMeta_d = faultCouplerOn;
    faultSync_d = faultMeta_q;
    faultPrev_d = faultSync_q;
    stepMeta_d  = stepPulse;
    stepSync_d  = stepMeta_q;
    dirMeta_d   = stepDir;
    dirSync_d   = dirMeta_q;
    // A coupler already conducting at reset release raises no event; the status word still shows it.
    faultArm_d  = faultArmed ? faultArm_q : faultArm_q + 2'h1;
  end
  assign faultArmed = &faultArm_q;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      icIdMeta_q  <= 4'h0;
      icId_q      <= 4'h0;
      faultMeta_q <= 4'h0;
      faultSync_q <= 4'h0;
      faultPrev_q <= 4'h0;
      stepMeta_q  <= 4'h0;
      stepSync_q  <= 4'h0;
      dirMeta_q   <= 4'h0;
      dirSync_q   <= 4'h0;
      faultArm_q  <= 2'h0;
    end else begin
      icIdMeta_q  <= icIdMeta_d;
      icId_q      <= icId_d;
      faultMeta_q <= faultMeta_d;
      faultSync_q <= faultSync_d;
      faultPrev_q <= faultPrev_d;
      stepMeta_q  <= stepMeta_d;
      stepSync_q  <= stepSync_d;
      dirMeta_q   <= dirMeta_d;
      dirSync_q   <= dirSync_d;
      faultArm_q  <= faultArm_d;
    end
  end

  // Strap changes need two cycles to reach this compare; software must not access the IC meanwhile.
  assign selected    = (busIcSel == icId_q);
  assign wrEn        = busWr & selected;
  assign rdEn        = busRd & selected;
  assign chanHit     = (busAddr >= OFF_CHAN_BASE) && (busAddr <= OFF_CHAN_END) && (busAddr[1:0] == 2'b00);
  assign chanIdx     = chan_index(busAddr);
  // Channel format words and the protection mask itself are guarded by the key.
  assign isProtected = chanHit || (busAddr == OFF_PROT_CTRL);
  // The key is compared whole, so a near miss locks the protected words just as zero does.
  assign keyOk       = (write_protect_key_q == WP_KEY_UNLOCK);
  assign faultStatus = ~faultSync_q;
  assign protWrOk      = wrEn && isProtected && keyOk;
  assign protWrRefused = wrEn && isProtected && !keyOk;

  // Only an accepted protected write uses up the key; a refused one leaves it for software to inspect.
  always_comb begin
    write_protect_key_d    = write_protect_key_q;
    protMask_d = protMask_q;
    irqMask_d  = irqMask_q;
    irqStat_d  = irqStat_q;
    for (int c = 0; c < NUM_CHAN; c++) begin
      chanFmt_d[c] = chanFmt_q[c];
    end
    if (wrEn) begin
      if (isProtected) begin
        if (keyOk) begin
          if (chanHit) begin
            chanFmt_d[chanIdx] = busWrData;
          end else begin
            protMask_d = busWrData;
          end
          write_protect_key_d = WP_KEY_RESET;
        end
      end else begin
        unique case (busAddr)
          OFF_WP_KEY:   write_protect_key_d = busWrData;
          OFF_IRQ_MASK: irqMask_d = busWrData[IRQ_W-1:0];
          OFF_IRQ_STAT: irqStat_d = irqStat_q & ~busWrData[IRQ_W-1:0];
          default:      write_protect_key_d = write_protect_key_q;
        endcase
      end
    end
    // Hardware events win over a write-one clear in the same cycle.
    if (protWrOk) begin
      irqStat_d[IRQ_PROT_WR] = 1'b1;
    end
    if (protWrRefused) begin
      irqStat_d[IRQ_REJECT] = 1'b1;
    end
    if (faultArmed && |(faultSync_q & ~faultPrev_q)) begin
      irqStat_d[IRQ_FAULT] = 1'b1;
    end
  end

  // Read data are zero outside their one-cycle slot, so several ICs can share one return path.
  always_comb begin
    rdData_d = UNMAPPED_DATA;
    if (rdEn) begin
      if (chanHit) begin
        rdData_d = chanFmt_q[chanIdx];
      end else begin
        unique case (busAddr)
          OFF_WP_KEY:    rdData_d = write_protect_key_q;
          OFF_IC_SEL:    rdData_d = nibble_word(icId_q);
          OFF_STATUS:    rdData_d = nibble_word(faultStatus);
          OFF_IRQ_STAT:  rdData_d = irq_word(irqStat_q);
          OFF_IRQ_MASK:  rdData_d = irq_word(irqMask_q);
          OFF_PROT_CTRL: rdData_d = protMask_q;
          default:       rdData_d = UNMAPPED_DATA;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      write_protect_key_q    <= WP_KEY_RESET;
      protMask_q <= REG_ZERO;
      irqStat_q  <= '0;
      irqMask_q  <= '0;
      rdData_q   <= REG_ZERO;
      for (int c = 0; c < NUM_CHAN; c++) begin
        chanFmt_q[c] <= REG_ZERO;
      end
    end else begin
      write_protect_key_q    <= write_protect_key_d;
      protMask_q <= protMask_d;
      irqStat_q  <= irqStat_d;
      irqMask_q  <= irqMask_d;
      rdData_q   <= rdData_d;
      for (int c = 0; c < NUM_CHAN; c++) begin
        chanFmt_q[c] <= chanFmt_d[c];
      end
    end
  end

  // Output mux is registered so the connector lines never glitch on a format change.
  logic [3:0] pdLow_d;
  logic [3:0] pdHigh_d;
  logic [3:0] pdLow_q;
  logic [3:0] pdHigh_q;
  logic [3:0] relay_q;
  logic [3:0] relay_d;

  always_comb begin
    // No inversion is offered; the sense of the relay is set by which contact is wired.
    relay_d = ampEnable;
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (chanFmt_q[c][FMT_PD_BIT]) begin
        pdLow_d[c]  = stepSync_q[c];
        pdHigh_d[c] = dirSync_q[c];
      end else begin
        pdLow_d[c]  = pwmLow[c];
        pdHigh_d[c] = pwmHigh[c];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      pdLow_q  <= 4'h0;
      pdHigh_q <= 4'h0;
      relay_q  <= 4'h0;
    end else begin
      pdLow_q  <= pdLow_d;
      pdHigh_q <= pdHigh_d;
      relay_q  <= relay_d;
    end
  end

  assign phase_d_low_side_output  = pdLow_q;
  assign phase_d_high_side_output = pdHigh_q;
  assign ampRelayOn               = relay_q;
  // Channels 0 and 1 sit on the base board, 2 and 3 on the piggyback board.
  assign channelBaseBoard         = 4'b0011;
  assign busRdData                = rdData_q;
  // The level drops as soon as software clears or masks the last pending bit.
  assign irq                      = |(irqStat_q & irqMask_q);
endmodule

// ==== psa_setup_access_properties.sv ====
`timescale 1ns/1ps
module psa_setup_access_properties
  import psa_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [3:0]  address_switch_bank,
  input wire logic [3:0]  busIcSel,
  input wire logic [7:0]  busAddr,
  input wire logic [31:0] busWrData,
  input wire logic        busWr,
  input wire logic        busRd,
  input wire logic [31:0] busRdData,
  input wire logic [3:0]  ampEnable,
  input wire logic [3:0]  faultCouplerOn,
  input wire logic [3:0]  ampRelayOn,
  input wire logic [3:0]  channelBaseBoard
);
  logic [2:0] upCnt_q, upCnt_d;
  // Requests before the synchronised reset and straps settle are not judged.
  always_comb upCnt_d = (upCnt_q == 3'h5) ? upCnt_q : upCnt_q + 3'h1;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) upCnt_q <= 3'h0;
    else upCnt_q <= upCnt_d;
  end
  wire live = upCnt_q == 3'h5;
  wire hit = live && busIcSel == address_switch_bank;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence sKeyWr; busWr && hit && busAddr == OFF_WP_KEY; endsequence
  sequence sKeyRd; busRd && hit && busAddr == OFF_WP_KEY; endsequence
  sequence sChanWr;
    busWr && hit && busAddr >= OFF_CHAN_BASE && busAddr <= OFF_CHAN_END && busAddr[1:0] == 2'h0;
  endsequence
  // Straps and coupler reach the read path through two flops, so they must hold for two cycles.
  sequence sSwSteady;
    $stable(address_switch_bank) && address_switch_bank == $past(address_switch_bank, 2);
  endsequence
  sequence sCoupSteady;
    $stable(faultCouplerOn) && faultCouplerOn == $past(faultCouplerOn, 2);
  endsequence
  a_key_readback: assert property (sKeyWr ##1 sKeyRd |=> busRdData == $past(busWrData, 2))
    else $error("key readback wrong");
  a_key_autoclear: assert property (sKeyWr ##0 busWrData == WP_KEY_UNLOCK ##1 sChanWr ##1 sKeyRd
    |=> busRdData == WP_KEY_RESET) else $error("key not cleared");
  a_key_kept: assert property (sKeyWr ##1 (busWr && hit && busAddr == OFF_IRQ_MASK) ##1 sKeyRd
    |=> busRdData == $past(busWrData, 3)) else $error("key lost");
  a_fault_raw: assert property (sCoupSteady ##0 (busRd && hit && busAddr == OFF_STATUS)
    |=> busRdData[3:0] == ~$past(faultCouplerOn)) else $error("fault status wrong");
  a_ic_number: assert property (sSwSteady ##0 (busRd && hit && busAddr == OFF_IC_SEL)
    |=> busRdData == 32'($past(address_switch_bank))) else $error("ic number wrong");
  a_ic_ignore: assert property (sSwSteady ##0 (busRd && live && (!hit || busAddr == 8'hFC))
    |=> busRdData == REG_ZERO) else $error("foreign read answered");
  a_rd_idle: assert property (live && !$past(busRd) |-> busRdData == REG_ZERO)
    else $error("read data outside slot");
  a_relay_fixed: assert property (live |-> ampRelayOn == $past(ampEnable))
    else $error("relay mismatch");
  a_base_board: assert property (channelBaseBoard == 4'h3)
    else $error("base board map wrong");
endmodule
bind psa_setup_access psa_setup_access_properties u_props (.ref_clk, .rst_n, .address_switch_bank,
  .busIcSel, .busAddr, .busWrData, .busWr, .busRd, .busRdData, .ampEnable, .faultCouplerOn,
  .ampRelayOn, .channelBaseBoard);

// ==== psa_setup_access_tb.sv ====
`timescale 1ns/1ps
module psa_setup_access_tb;
  import psa_pkg::*;
  logic        ref_clk = 1'b0, rst_n = 1'b0, busWr = 1'b0, busRd = 1'b0, chkQ = 1'b0, chk2 = 1'b0;
  logic        loadKey = 1'b0, irq;
  logic [3:0]  address_switch_bank = 4'h5, busIcSel = 4'h5, stepPulse = 4'h5, stepDir = 4'h3;
  logic [3:0]  pwmLow = 4'hA, pwmHigh = 4'hC, ampEnable = 4'hA, faultCouplerOn = 4'h6;
  logic [3:0]  phase_d_low_side_output, phase_d_high_side_output, ampRelayOn, channelBaseBoard, faultSeen;
  logic [7:0]  busAddr = 8'h00;
  logic [31:0] busWrData = 32'h0000_0000, expQ = 32'h0000_0000, exp2, gkey, busRdData;
  int          err_count = 0;
  int          n_tests = 0;
  psa_setup_access DUT (.ref_clk, .rst_n, .address_switch_bank, .busIcSel, .busAddr, .busWrData,
    .busWr, .busRd, .busRdData, .stepPulse, .stepDir, .pwmLow, .pwmHigh, .ampEnable, .faultCouplerOn,
    .phase_d_low_side_output, .phase_d_high_side_output, .ampRelayOn, .channelBaseBoard, .irq);
  psa_host_model HOST (.ref_clk, .rst_n, .loadKey, .keyIn(WP_KEY_UNLOCK), .statusRaw(busRdData[3:0]),
    .faultActive(faultSeen), .globalKeyCopy_q(gkey));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic test_done;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, r, input logic [7:0] a, input logic [31:0] d, e);
    busWr <= w;
    busRd <= r;
    busAddr <= a;
    busWrData <= d;
    chkQ <= r;
    expQ <= e;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, 1'b0, a, d, REG_ZERO);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, 1'b1, a, REG_ZERO, e);
  endtask
  // Read data stand only in the cycle after the strobe, so they are judged one edge later.
  always @(posedge ref_clk) begin
    chk2 <= chkQ;
    exp2 <= expQ;
  end
  always @(negedge ref_clk) if (chk2 === 1'b1) chk(busRdData, exp2);
  initial begin
    repeat (2000) @(posedge ref_clk);
    err_count++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(OFF_WP_KEY, WP_KEY_RESET);
    wr(OFF_WP_KEY, WP_KEY_UNLOCK);
    wr(OFF_CHAN_BASE, 32'h0000_0008);
    rd(OFF_WP_KEY, WP_KEY_RESET);
    rd(OFF_CHAN_BASE, 32'h0000_0008);
    wr(OFF_WP_KEY, WP_KEY_UNLOCK);
    wr(OFF_IRQ_MASK, 32'h0000_0002);
    rd(OFF_WP_KEY, WP_KEY_UNLOCK);
    wr(OFF_WP_KEY, 32'hAAAA_AAAB);
    rd(OFF_WP_KEY, 32'hAAAA_AAAB);
    wr(8'h24, 32'h0000_000F);
    rd(8'h24, REG_ZERO);
    rd(OFF_WP_KEY, 32'hAAAA_AAAB);
    acc(1'b0, 1'b0, 8'h00, REG_ZERO, REG_ZERO);
    @(negedge ref_clk);
    chk(32'(irq), 32'h0000_0001);
    @(posedge ref_clk);
    wr(OFF_IRQ_STAT, 32'h0000_0002);
    acc(1'b0, 1'b0, 8'h00, REG_ZERO, REG_ZERO);
    @(negedge ref_clk);
    chk(32'(irq), REG_ZERO);
    @(posedge ref_clk);
    loadKey <= 1'b1;
    @(posedge ref_clk);
    loadKey <= 1'b0;
    @(posedge ref_clk);
    wr(OFF_WP_KEY, gkey);
    wr(8'h28, 32'h0000_000F);
    wr(OFF_WP_KEY, gkey);
    wr(8'h24, 32'h0000_0007);
    rd(8'h24, 32'h0000_0007);
    acc(1'b0, 1'b0, 8'h00, REG_ZERO, REG_ZERO);
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(32'(phase_d_low_side_output), 32'h0000_000F);
    chk(32'(phase_d_high_side_output), 32'h0000_0009);
    chk(32'(ampRelayOn), 32'h0000_000A);
    chk(32'(channelBaseBoard), 32'h0000_0003);
    @(posedge ref_clk);
    rd(OFF_IC_SEL, 32'h0000_0005);
    rd(OFF_STATUS, 32'h0000_0009);
    busRd <= 1'b0;
    chkQ <= 1'b0;
    @(negedge ref_clk);
    chk(32'(faultSeen), 32'(faultCouplerOn));
    @(posedge ref_clk);
    rd(8'hFC, UNMAPPED_DATA);
    busIcSel <= 4'h6;
    rd(OFF_IC_SEL, REG_ZERO);
    acc(1'b0, 1'b0, 8'h00, REG_ZERO, REG_ZERO);
    repeat (2) @(posedge ref_clk);
    test_done();
  end
endmodule
